// ==== icsr_pkg.sv ====
package icsr_pkg;
    localparam int NUM_CH = 4;
    localparam logic [28:0] ID_BROADCAST = 29'h000003FF;
    localparam logic [3:0] DLC_WRITE = 4'h5;
    localparam logic [3:0] DLC_READ = 4'h4;
    localparam logic [7:0] FN_WRITE = 8'h01;
    localparam logic [7:0] FN_READ = 8'h02;
    localparam logic [15:0] A_ONOFF = 16'h0000;
    localparam logic [15:0] A_CUR_SET = 16'h0002;
    localparam logic [15:0] A_VOLT_SET = 16'h0024;
    localparam logic [15:0] A_TOPO = 16'h0035;
    localparam logic [15:0] A_TEMP_A = 16'h0200;
    localparam logic [15:0] A_TEMP_B = 16'h0201;
    localparam logic [15:0] A_UNIT_STATE = 16'h0206;
    localparam logic [15:0] A_UNIT_FAULT = 16'h0207;
    localparam logic [15:0] A_CH_STATE_LO = 16'h0208;
    localparam logic [15:0] A_CH_STATE_HI = 16'h0209;
    localparam logic [15:0] A_CH_FAULT = 16'h020A;
    localparam logic [15:0] A_CH_TYPE = 16'h020B;
    localparam logic [15:0] ONOFF_ON = 16'hFFAA;
    localparam logic [15:0] ONOFF_OFF = 16'hFF55;
    localparam logic [15:0] RST_SETPOINT = 16'h0000;
    localparam logic [15:0] RST_TOPO = 16'h0000;
    localparam int BIT_AC = 8;
    localparam int BIT_LINK = 9;
    localparam int BIT_CBC = 10;
    localparam int BIT_BOOST_OV = 0;
    localparam int BIT_IN_OV = 2;
    localparam int BIT_IN_UNDER = 3;
    localparam int BIT_BUS_OV = 4;
    localparam int BIT_OVER_TEMP = 6;
    localparam int BIT_IN_OVER = 7;
    localparam int IQ6_SHIFT = 6;
    localparam int IN_OV_LV_VOLTS = 63;
    localparam int IN_OV_HV_VOLTS = 435;
    localparam int BUS_OV_VOLTS = 406;
    localparam logic [15:0] IN_OV_LV_CODE = 16'(IN_OV_LV_VOLTS << IQ6_SHIFT);
    localparam logic [15:0] IN_OV_HV_CODE = 16'(IN_OV_HV_VOLTS << IQ6_SHIFT);
    localparam logic [15:0] BUS_OV_CODE = 16'(BUS_OV_VOLTS << IQ6_SHIFT);
    localparam int DEV_PERCENT = 10;
    localparam int CLK_MHZ = 125;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_MHZ * 1000 * TICK_MS;
    localparam int BURNIN_DELAY_S = 25;
    localparam int BURNIN_DELAY_MS = BURNIN_DELAY_S * 1000;

    typedef enum logic [1:0] {
        ICSR_OFFLINE = 2'h0,
        ICSR_RUNNING = 2'h1,
        ICSR_FAULTED = 2'h2,
        ICSR_STANDBY = 2'h3
    } icsr_run_t;

    typedef struct packed {
        logic [28:0] id;
        logic [3:0] dlc;
        logic [7:0][7:0] data;
    } icsr_frame_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic ok;
    } icsr_resp_t;
endpackage : icsr_pkg

// ==== icsr_chan_mon.sv ====
`timescale 1ns/1ps
`default_nettype none
module icsr_chan_mon
    import icsr_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [15:0] vin,
    input wire logic [15:0] vout,
    input wire logic [15:0] dut_volts,
    input wire logic hv_model,
    input wire logic dev_enable,
    input wire logic boost_ov,
    input wire logic over_temp,
    output logic [7:0] flags_reg
);
    logic [19:0] vin_x10;
    logic [19:0] dut_x9;
    logic [19:0] dut_x11;
    logic [15:0] in_ov_limit;

    assign vin_x10 = 20'(vin) * 20'(DEV_PERCENT);
    assign dut_x9 = 20'(dut_volts) * 20'(DEV_PERCENT - 1);
    assign dut_x11 = 20'(dut_volts) * 20'(DEV_PERCENT + 1);
    assign in_ov_limit = hv_model ? IN_OV_HV_CODE : IN_OV_LV_CODE;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flags_reg <= 8'h00;
        end else begin
            flags_reg <= 8'h00;
            flags_reg[BIT_BOOST_OV] <= boost_ov;
            flags_reg[BIT_OVER_TEMP] <= over_temp;
            flags_reg[BIT_IN_OV] <= vin > in_ov_limit;
            flags_reg[BIT_BUS_OV] <= vout > BUS_OV_CODE;
            flags_reg[BIT_IN_UNDER] <= dev_enable && vin_x10 < dut_x9;
            flags_reg[BIT_IN_OVER] <= dev_enable && vin_x10 > dut_x11;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_in_ov;
        vin > in_ov_limit |=> flags_reg[BIT_IN_OV];
    endproperty
    a_in_ov: assert property (p_in_ov) else $error("input ov missed");
    property p_bus_ov;
        flags_reg[BIT_BUS_OV] |-> $past(vout) > BUS_OV_CODE;
    endproperty
    a_bus_ov: assert property (p_bus_ov) else $error("bus ov wrong");
    property p_dev_masked;
        !dev_enable |=> !flags_reg[BIT_IN_UNDER] && !flags_reg[BIT_IN_OVER];
    endproperty
    a_dev_masked: assert property (p_dev_masked)
        else $error("deviation while masked");
    property p_unused_zero;
        flags_reg[1] == 1'b0 && flags_reg[5] == 1'b0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused fault bit set");
endmodule : icsr_chan_mon
`default_nettype wire

// ==== icsr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module icsr_regs
    import icsr_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int BURNIN_TICKS = BURNIN_DELAY_MS
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire icsr_frame_t rx_frame,
    input wire logic rx_valid,
    input wire logic hv_strap,
    input wire logic ac_fault_pin,
    input wire logic link_loss_pin,
    input wire logic cycle_overcurrent_pin,
    input wire logic [NUM_CH-1:0][15:0] ch_vin,
    input wire logic [NUM_CH-1:0][15:0] ch_vout,
    input wire logic [NUM_CH-1:0][3:0] ch_type,
    input wire logic [NUM_CH-1:0] ch_boost_ov,
    input wire logic [NUM_CH-1:0] ch_over_temp,
    input wire logic [15:0] dut_volts,
    input wire logic [15:0] heatsink_temp_a,
    input wire logic [15:0] heatsink_temp_b,
    output icsr_resp_t resp_reg,
    output logic resp_valid_reg,
    output logic run_on_reg,
    output logic [15:0] current_setpoint_reg,
    output logic [15:0] voltage_setpoint_reg,
    output logic [15:0] topology_mode_ctrl_reg
);
    // ------------------------------------------------------------
    // Pin synchronisers and strap capture
    // ------------------------------------------------------------
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic hv_model_reg;
    logic [1:0] strap_age_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end else begin
            pin_meta_reg <= {hv_strap, cycle_overcurrent_pin,
                             link_loss_pin, ac_fault_pin};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // The model strap is sampled on the first three cycles after reset and then held; the last sample has passed the synchroniser.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hv_model_reg <= 1'b0;
            strap_age_reg <= 2'h0;
        end else if (strap_age_reg != 2'h3) begin
            strap_age_reg <= strap_age_reg + 2'h1;
            hv_model_reg <= pin_sync_reg[3];
        end
    end

    // ------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------
    logic [7:0] fn;
    logic [15:0] f_addr;
    logic [15:0] f_data;
    logic wr_hit;
    logic rd_hit;

    assign fn = rx_frame.data[0];
    assign f_addr = {rx_frame.data[1], rx_frame.data[2]};
    assign f_data = {rx_frame.data[3], rx_frame.data[4]};
    assign wr_hit = rx_valid && rx_frame.id == ID_BROADCAST
                    && rx_frame.dlc == DLC_WRITE && fn == FN_WRITE;
    assign rd_hit = rx_valid && rx_frame.dlc == DLC_READ && fn == FN_READ;

    // ------------------------------------------------------------
    // Setting registers
    // ------------------------------------------------------------
    logic burnin_start;

    assign burnin_start = wr_hit && f_addr == A_ONOFF
                          && f_data == ONOFF_ON && !run_on_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run_on_reg <= 1'b0;
        end else if (wr_hit && f_addr == A_ONOFF) begin
            if (f_data == ONOFF_ON) begin
                run_on_reg <= 1'b1;
            end else if (f_data == ONOFF_OFF) begin
                run_on_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            current_setpoint_reg <= RST_SETPOINT;
            voltage_setpoint_reg <= RST_SETPOINT;
            topology_mode_ctrl_reg <= RST_TOPO;
        end else if (wr_hit) begin
            unique case (f_addr)
                A_CUR_SET: current_setpoint_reg <= f_data;
                A_VOLT_SET: voltage_setpoint_reg <= f_data;
                A_TOPO: topology_mode_ctrl_reg <= f_data;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Burn-in start-up mask
    // ------------------------------------------------------------
    logic [$clog2(TICK_LEN)-1:0] div_reg;
    logic tick_reg;
    logic [$clog2(BURNIN_TICKS+1)-1:0] burnin_cnt_reg;
    logic dev_enable_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= div_reg == $bits(div_reg)'(TICK_LEN - 1);
            if (div_reg == $bits(div_reg)'(TICK_LEN - 1)) begin
                div_reg <= '0;
            end else begin
                div_reg <= div_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            burnin_cnt_reg <= '0;
            dev_enable_reg <= 1'b0;
        end else if (burnin_start || !run_on_reg) begin
            burnin_cnt_reg <= '0;
            dev_enable_reg <= 1'b0;
        end else if (burnin_cnt_reg
                     == $bits(burnin_cnt_reg)'(BURNIN_TICKS)) begin
            dev_enable_reg <= 1'b1;
        end else if (tick_reg) begin
            burnin_cnt_reg <= burnin_cnt_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Channel monitors and status
    // ------------------------------------------------------------
    logic [NUM_CH-1:0][7:0] ch_flags;
    logic [15:0] unit_fault_reg;
    logic [15:0] ch_fault_reg;
    logic [31:0] ch_state_reg;
    logic [1:0] unit_state_reg;

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        icsr_chan_mon u_mon (
            .clock(clock),
            .rstn(rstn),
            .vin(ch_vin[c]),
            .vout(ch_vout[c]),
            .dut_volts(dut_volts),
            .hv_model(hv_model_reg),
            .dev_enable(dev_enable_reg),
            .boost_ov(ch_boost_ov[c]),
            .over_temp(ch_over_temp[c]),
            .flags_reg(ch_flags[c])
        );
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            unit_fault_reg <= 16'h0000;
        end else begin
            unit_fault_reg <= 16'h0000;
            unit_fault_reg[BIT_AC] <= pin_sync_reg[0];
            unit_fault_reg[BIT_LINK] <= pin_sync_reg[1];
            unit_fault_reg[BIT_CBC] <= pin_sync_reg[2];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ch_fault_reg <= 16'h0000;
        end else begin
            ch_fault_reg <= {8'h00, ch_flags[0] | ch_flags[1]
                             | ch_flags[2] | ch_flags[3]};
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ch_state_reg <= 32'h0000_0000;
        end else begin
            ch_state_reg <= 32'h0000_0000;
            for (int c = 0; c < NUM_CH; c++) begin
                if (ch_type[c] == 4'h0) begin
                    ch_state_reg[2*c +: 2] <= ICSR_OFFLINE;
                end else if (ch_flags[c] != 8'h00) begin
                    ch_state_reg[2*c +: 2] <= ICSR_FAULTED;
                end else if (run_on_reg) begin
                    ch_state_reg[2*c +: 2] <= ICSR_RUNNING;
                end else begin
                    ch_state_reg[2*c +: 2] <= ICSR_STANDBY;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            unit_state_reg <= ICSR_STANDBY;
        end else if ((|unit_fault_reg) || (|ch_fault_reg)) begin
            unit_state_reg <= ICSR_FAULTED;
        end else if (run_on_reg) begin
            unit_state_reg <= ICSR_RUNNING;
        end else begin
            unit_state_reg <= ICSR_STANDBY;
        end
    end

    // ------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------
    icsr_resp_t rd_next;

    always_comb begin
        rd_next.addr = f_addr;
        rd_next.data = 16'h0000;
        rd_next.ok = 1'b1;
        unique case (f_addr)
            A_ONOFF: rd_next.data = run_on_reg ? ONOFF_ON : ONOFF_OFF;
            A_CUR_SET: rd_next.data = current_setpoint_reg;
            A_VOLT_SET: rd_next.data = voltage_setpoint_reg;
            A_TOPO: rd_next.data = topology_mode_ctrl_reg;
            A_TEMP_A: rd_next.data = heatsink_temp_a;
            A_TEMP_B: rd_next.data = heatsink_temp_b;
            A_UNIT_STATE: rd_next.data = {14'h0000, unit_state_reg};
            A_UNIT_FAULT: rd_next.data = unit_fault_reg;
            A_CH_STATE_LO: rd_next.data = ch_state_reg[15:0];
            A_CH_STATE_HI: rd_next.data = ch_state_reg[31:16];
            A_CH_FAULT: rd_next.data = ch_fault_reg;
            A_CH_TYPE: rd_next.data = {ch_type[3], ch_type[2],
                                       ch_type[1], ch_type[0]};
            default: rd_next.ok = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            resp_reg <= '0;
            resp_valid_reg <= 1'b0;
        end else begin
            resp_valid_reg <= rd_hit;
            if (rd_hit) begin
                resp_reg <= rd_next;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_wr(logic [15:0] a);
        wr_hit && f_addr == a;
    endsequence

    property p_on;
        s_wr(A_ONOFF) ##0 (f_data == ONOFF_ON) |=> run_on_reg;
    endproperty
    a_on: assert property (p_on) else $error("on code ignored");
    property p_volt;
        s_wr(A_VOLT_SET) |=> voltage_setpoint_reg == $past(f_data);
    endproperty
    a_volt: assert property (p_volt) else $error("volt set lost");
    property p_status_ro;
        s_wr(A_UNIT_STATE) |=> $stable(current_setpoint_reg)
            && $stable(voltage_setpoint_reg);
    endproperty
    a_status_ro: assert property (p_status_ro)
        else $error("status write took effect");
    property p_read;
        rd_hit |=> resp_valid_reg && resp_reg.addr == $past(f_addr);
    endproperty
    a_read: assert property (p_read) else $error("read unanswered");
    property p_unit_fault;
        unit_fault_reg != 16'h0000 |=> unit_state_reg == ICSR_FAULTED;
    endproperty
    a_unit_fault: assert property (p_unit_fault)
        else $error("unit not faulted");
    property p_upper_ch;
        ch_state_reg[31:2*NUM_CH] == '0;
    endproperty
    a_upper_ch: assert property (p_upper_ch)
        else $error("reserved channel state set");
    property p_agg;
        ch_flags[0][BIT_BUS_OV] |=> ch_fault_reg[BIT_BUS_OV];
    endproperty
    a_agg: assert property (p_agg) else $error("aggregate stale");
    property p_unit_bits;
        unit_fault_reg[7:0] == 8'h00 && unit_fault_reg[15:11] == 5'h00;
    endproperty
    a_unit_bits: assert property (p_unit_bits)
        else $error("undefined unit fault bit");
    property p_mask_start;
        burnin_start |=> (!dev_enable_reg) [*2];
    endproperty
    a_mask_start: assert property (p_mask_start)
        else $error("deviation armed early");
endmodule : icsr_regs
`default_nettype wire

// ==== icsr_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Remote controller that issues setting and status frames.
// ----------------------------------------------------------------
module icsr_ctrl_model
    import icsr_pkg::*;
(
    input wire logic clock,
    output icsr_frame_t rx_frame,
    output logic rx_valid
);
    initial begin
        rx_frame = '0;
        rx_valid = 1'b0;
    end

    task automatic send(input logic [28:0] id, input logic [3:0] dlc,
            input logic [7:0] fn, input logic [15:0] a,
            input logic [15:0] d);
        icsr_frame_t f;
        f.id = id;
        f.dlc = dlc;
        f.data = {8'h5A, 8'hA5, 8'h5A, d[7:0], d[15:8], a[7:0], a[15:8], fn};
        @(posedge clock);
        rx_frame <= f;
        rx_valid <= 1'b1;
        @(posedge clock);
        rx_valid <= 1'b0;
        // The bus no longer shows the last frame once it has passed.
        rx_frame <= ~f;
    endtask : send

    task automatic write(input logic [15:0] a, input logic [15:0] d);
        send(ID_BROADCAST, DLC_WRITE, FN_WRITE, a, d);
    endtask : write

    task automatic read(input logic [15:0] a);
        send(29'h0000033F, DLC_READ, FN_READ, a, 16'h0200);
    endtask : read
endmodule : icsr_ctrl_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Self-checking bench for the status and setting registers.
// ----------------------------------------------------------------
module tb;
    import icsr_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    icsr_frame_t rx_frame;
    logic rx_valid;
    logic hv_strap, ac_fault_pin, link_loss_pin, cycle_overcurrent_pin;
    logic [NUM_CH-1:0][15:0] ch_vin, ch_vout;
    logic [NUM_CH-1:0][3:0] ch_type;
    logic [NUM_CH-1:0] ch_boost_ov, ch_over_temp;
    logic [15:0] dut_volts, heatsink_temp_a, heatsink_temp_b;
    icsr_resp_t resp_reg;
    logic resp_valid_reg, run_on_reg;
    logic [15:0] current_setpoint_reg, voltage_setpoint_reg;
    logic [15:0] topology_mode_ctrl_reg;
    int errors = 0;
    int total_checks = 0;
    logic [15:0] cur_sp = 16'h0000, volt_sp = 16'h0000, topo = 16'h0000;
    logic [15:0] onv = ONOFF_OFF;
    logic run_on = 1'b0, dev_en = 1'b0, hv = 1'b0;
    logic [31:0] seed = 32'hDDD07F6A;

    always #4 clock = ~clock;

    icsr_ctrl_model i_ctrl (.clock(clock), .rx_frame(rx_frame),
        .rx_valid(rx_valid));
    icsr_regs #(.TICK_LEN(4), .BURNIN_TICKS(5)) i_dut (.clock(clock),
        .rstn(rstn), .rx_frame(rx_frame), .rx_valid(rx_valid),
        .hv_strap(hv_strap), .ac_fault_pin(ac_fault_pin),
        .link_loss_pin(link_loss_pin),
        .cycle_overcurrent_pin(cycle_overcurrent_pin), .ch_vin(ch_vin),
        .ch_vout(ch_vout), .ch_type(ch_type), .ch_boost_ov(ch_boost_ov),
        .ch_over_temp(ch_over_temp), .dut_volts(dut_volts),
        .heatsink_temp_a(heatsink_temp_a), .heatsink_temp_b(heatsink_temp_b),
        .resp_reg(resp_reg), .resp_valid_reg(resp_valid_reg),
        .run_on_reg(run_on_reg), .current_setpoint_reg(current_setpoint_reg),
        .voltage_setpoint_reg(voltage_setpoint_reg),
        .topology_mode_ctrl_reg(topology_mode_ctrl_reg));

    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : lfsr

    function automatic logic [7:0] flags(int n);
        logic [7:0] f;
        int v;
        int d;
        v = ch_vin[n];
        d = dut_volts;
        f = 8'h00;
        f[BIT_BOOST_OV] = ch_boost_ov[n];
        f[BIT_IN_OV] = v > (hv ? IN_OV_HV_VOLTS : IN_OV_LV_VOLTS) * 64;
        f[BIT_IN_UNDER] = dev_en && v * 10 < d * 9;
        f[BIT_BUS_OV] = int'(ch_vout[n]) > BUS_OV_VOLTS * 64;
        f[BIT_OVER_TEMP] = ch_over_temp[n];
        f[BIT_IN_OVER] = dev_en && v * 10 > d * 11;
        return f;
    endfunction : flags

    function automatic logic [15:0] chf();
        logic [15:0] r;
        r = 16'h0000;
        for (int n = 0; n < NUM_CH; n++) r |= {8'h00, flags(n)};
        return r;
    endfunction : chf

    function automatic logic [15:0] exp_rd(logic [15:0] a);
        logic [15:0] uf;
        logic [15:0] r;
        uf = {5'h00, cycle_overcurrent_pin, link_loss_pin, ac_fault_pin, 8'h00};
        r = 16'h0000;
        case (a)
            A_ONOFF: r = onv;
            A_CUR_SET: r = cur_sp;
            A_VOLT_SET: r = volt_sp;
            A_TOPO: r = topo;
            A_TEMP_A: r = heatsink_temp_a;
            A_TEMP_B: r = heatsink_temp_b;
            A_UNIT_STATE: r = (uf != 0 || chf() != 0) ? 16'h0002 :
                (run_on ? 16'h0001 : 16'h0003);
            A_UNIT_FAULT: r = uf;
            A_CH_STATE_LO: for (int n = 0; n < NUM_CH; n++) begin
                r[2*n+:2] = ch_type[n] == 0 ? 2'h0 : chf() != 0 &&
                    flags(n) != 0 ? 2'h2 : (run_on ? 2'h1 : 2'h3);
            end
            A_CH_FAULT: r = chf();
            A_CH_TYPE: r = ch_type;
            default: r = 16'h0000;
        endcase
        return r;
    endfunction : exp_rd

    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rdchk(input logic [15:0] a, input logic ok);
        int n;
        i_ctrl.read(a);
        n = 0;
        #1;
        while (resp_valid_reg !== 1'b1 && n < 4) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("resp_valid", 1, resp_valid_reg);
        chk("resp_addr", a, resp_reg.addr);
        chk("resp_ok", ok, resp_reg.ok);
        chk("resp_data", exp_rd(a), resp_reg.data);
        @(posedge clock);
        #1;
        chk("resp_drop", 0, resp_valid_reg);
    endtask : rdchk

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        i_ctrl.write(a, d);
        case (a)
            A_CUR_SET: cur_sp = d;
            A_VOLT_SET: volt_sp = d;
            A_TOPO: topo = d;
            A_ONOFF: if (d == ONOFF_ON || d == ONOFF_OFF) begin
                onv = d;
                run_on = d == ONOFF_ON;
            end
            default: ;
        endcase
        #1;
        chk("cur_sp", cur_sp, current_setpoint_reg);
        chk("volt_sp", volt_sp, voltage_setpoint_reg);
        chk("topo", topo, topology_mode_ctrl_reg);
        chk("run_on", run_on, run_on_reg);
    endtask : wr

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        #200000;
        errors++;
        test_done();
    end

    initial begin
        {hv_strap, ac_fault_pin, link_loss_pin, cycle_overcurrent_pin} = '0;
        ch_vin = {4{16'h0A00}};
        dut_volts = 16'h0A00;
        ch_vout = '0;
        ch_type = 16'h4031;
        {ch_boost_ov, ch_over_temp} = '0;
        heatsink_temp_a = 16'h0016;
        heatsink_temp_b = 16'h0019;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        rdchk(A_CUR_SET, 1);
        rdchk(A_VOLT_SET, 1);
        rdchk(A_TOPO, 1);
        rdchk(A_UNIT_STATE, 1);
        $display("test reset done");
        wr(A_VOLT_SET, 16'h0F00);
        wr(A_CUR_SET, 16'h7D00);
        for (int h = 0; h < 5; h++) begin
            for (int l = 0; l < 2; l++) wr(A_TOPO, {h[7:0], l[7:0]});
        end
        i_ctrl.send(29'h000003FE, DLC_WRITE, FN_WRITE, A_VOLT_SET, 16'h1234);
        i_ctrl.send(ID_BROADCAST, 4'h6, FN_WRITE, A_VOLT_SET, 16'h1234);
        i_ctrl.send(ID_BROADCAST, DLC_WRITE, 8'h03, A_VOLT_SET, 16'h1234);
        wr(A_CUR_SET, 16'(lfsr()));
        rdchk(A_VOLT_SET, 1);
        rdchk(A_CUR_SET, 1);
        $display("test settings done");
        wr(A_UNIT_STATE, 16'h0001);
        rdchk(A_UNIT_STATE, 1);
        rdchk(16'h0100, 0);
        $display("test refusals done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            {cycle_overcurrent_pin, link_loss_pin, ac_fault_pin} <= 3'h1 << i;
            repeat (6) @(posedge clock);
            rdchk(A_UNIT_FAULT, 1);
            rdchk(A_UNIT_STATE, 1);
        end
        $display("test unit faults done");
        @(posedge clock);
        ch_vin[0] <= 16'd4032;
        ch_vout[1] <= 16'd25984;
        ch_type <= 16'(lfsr());
        heatsink_temp_a <= 16'(lfsr());
        repeat (6) @(posedge clock);
        rdchk(A_CH_FAULT, 1);
        rdchk(A_TEMP_A, 1);
        rdchk(A_TEMP_B, 1);
        rdchk(A_CH_TYPE, 1);
        @(posedge clock);
        ch_vin[0] <= 16'd4033;
        ch_vout[1] <= 16'd25985;
        ch_boost_ov[2] <= 1'b1;
        ch_over_temp[3] <= 1'b1;
        ch_type <= 16'h0341;
        repeat (6) @(posedge clock);
        rdchk(A_CH_FAULT, 1);
        rdchk(A_CH_STATE_LO, 1);
        rdchk(A_CH_STATE_HI, 1);
        rdchk(A_UNIT_STATE, 1);
        $display("test channel faults done");
        @(posedge clock);
        ch_vin <= {16'h0A00, 16'h0A00, 16'h0B40, 16'h08C0};
        ch_vout <= '0;
        {ch_boost_ov, ch_over_temp} <= '0;
        wr(A_TOPO, 16'h0001);
        wr(A_CUR_SET, 16'hFFFF);
        wr(A_ONOFF, 16'h1234);
        wr(A_ONOFF, ONOFF_ON);
        rdchk(A_CH_FAULT, 1);
        rdchk(A_CH_STATE_LO, 1);
        repeat (40) @(posedge clock);
        dev_en = 1'b1;
        rdchk(A_CH_FAULT, 1);
        wr(A_ONOFF, ONOFF_OFF);
        dev_en = 1'b0;
        repeat (4) @(posedge clock);
        rdchk(A_CH_FAULT, 1);
        rdchk(A_ONOFF, 1);
        $display("test burn-in done");
        // high-voltage limit after a second reset
        @(posedge clock);
        rstn <= 1'b0;
        hv_strap <= 1'b1;
        ch_vin[0] <= 16'd27840;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        {cur_sp, volt_sp, topo} = '0;
        onv = ONOFF_OFF;
        run_on = 1'b0;
        hv = 1'b1;
        repeat (6) @(posedge clock);
        rdchk(A_TOPO, 1);
        rdchk(A_CH_FAULT, 1);
        @(posedge clock);
        ch_vin[0] <= 16'd27841;
        repeat (6) @(posedge clock);
        rdchk(A_CH_FAULT, 1);
        rdchk(A_UNIT_STATE, 1);
        $display("test high-voltage model done");
        test_done();
    end
endmodule : tb
`default_nettype wire
